// ===== hw/spsr_regs.sv
`timescale 1ns/100ps
`include "spsr_params.svh"

// Operation
// - Byte field counts Golay-detected bit errors over 82 headers per frame.
// - Bits 10 to 13 show presence of the four selected sound channels.
// - Bit 14 goes high once a matching packet 0 was received.
// - Coding law word holds four 4-bit fields, channel one lowest.
// - Each field holds law, protection, quality and stereo flags.
// - Syndrome word: low byte bits 0-7, high byte 8-15; zero sum means clean.
// - Packet 0 data word at address 210, low byte in bits 0-7.
// - Arm bit readies capture of next packet; rewind bit points at byte one.

module spsr_regs #(
  parameter int PKT_DEPTH = 64
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire spsr_pkg::spsr_req_t     req,
  output logic [15:0]                  rd_data,
  output logic                         rd_valid,
  input  wire logic                    hdr_done,
  input  wire logic [2:0]              hdr_err_bits,
  input  wire logic                    frame_start,
  input  wire spsr_pkg::spsr_sound_t   sound_in,
  input  wire spsr_pkg::spsr_byte_t    pkt_in,
  input  wire logic [15:0]             syndrome_in,
  output logic [3:0]                   sbus_chan_enable,
  output logic                         sbus_out_disable,
  output logic                         descrambler_enable,
  output logic                         concealment_disable,
  output logic [15:0]                  test_bits
);

  logic [15:0]         ctrl_reg;
  logic [15:0]         test_reg;
  logic [7:0]          err_acc_reg;
  logic [6:0]          hdr_cnt_reg;
  logic [7:0]          err_count_reg;
  spsr_pkg::spsr_sound_t sound_reg;
  logic [15:0]         rd_data_reg;
  logic                rd_valid_reg;
  logic [15:0]         rd_data_next;
  logic                received;
  logic [15:0]         data_word;
  logic [15:0]         syndrome;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  wire hit_ctrl   = req.addr == `SPSR_ADDR_CTRL;
  wire hit_test   = req.addr == `SPSR_ADDR_TEST;
  wire hit_status = req.addr == `SPSR_ADDR_STATUS;
  wire hit_law    = req.addr == `SPSR_ADDR_LAW;
  wire hit_synd   = req.addr == `SPSR_ADDR_SYND;
  wire hit_data   = req.addr == `SPSR_ADDR_DATA;
  // Only the control and test words accept writes
  wire wr_ctrl    = req.wr && hit_ctrl;
  wire wr_test    = req.wr && hit_test;
  // Arm and rewind are strobes; they are never stored
  wire pkt_arm    = wr_ctrl && req.wdata[`SPSR_CTRL_ARM];
  wire pkt_rewind = wr_ctrl && req.wdata[`SPSR_CTRL_REWIND];
  // Reading the data word steps on to the next byte pair
  wire pkt_adv    = req.rd && hit_data;
  wire [3:0] group_type_select =
    ctrl_reg[`SPSR_CTRL_DGT_LSB +: 4];

  // ****************************************************************
  // Writable words
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= `SPSR_CTRL_RESET;
      test_reg <= `SPSR_TEST_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= req.wdata & `SPSR_CTRL_WMASK;
      end
      if (wr_test) begin
        test_reg <= req.wdata;
      end
    end
  end

  // ****************************************************************
  // Header error counting
  // ****************************************************************
  // Saturating sum so a bad frame cannot wrap back to a small count
  wire [8:0] err_sum = {1'b0, err_acc_reg} + {6'h00, hdr_err_bits};
  wire [7:0] err_sat = err_sum[8] ? 8'hFF : err_sum[7:0];
  wire       last_hdr = hdr_done &&
                        hdr_cnt_reg == `SPSR_HDRS_PER_FRAME - 7'h01;

  // Count the headers of one frame and publish the total at the last
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      err_acc_reg   <= 8'h00;
      hdr_cnt_reg   <= 7'h00;
      err_count_reg <= 8'h00;
    end else if (frame_start) begin
      err_acc_reg <= 8'h00;
      hdr_cnt_reg <= 7'h00;
    end else if (last_hdr) begin
      err_count_reg <= err_sat;
      err_acc_reg   <= 8'h00;
      hdr_cnt_reg   <= 7'h00;
    end else if (hdr_done) begin
      err_acc_reg <= err_sat;
      hdr_cnt_reg <= hdr_cnt_reg + 7'h01;
    end
  end

  // ****************************************************************
  // Sound channel status
  // ****************************************************************
  // Registered so a read never sees a half-updated word
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sound_reg <= '0;
    end else begin
      sound_reg <= sound_in;
    end
  end

  // ****************************************************************
  // Packet 0 buffer
  // ****************************************************************
  spsr_pkt0_buf #(
    .DEPTH (PKT_DEPTH)
  ) u_pkt0 (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .arm               (pkt_arm),
    .rewind            (pkt_rewind),
    .advance           (pkt_adv),
    .group_type_select (group_type_select),
    .pkt_in            (pkt_in),
    .syndrome_in       (syndrome_in),
    .received          (received),
    .data_word         (data_word),
    .syndrome          (syndrome)
  );

  // ****************************************************************
  // Read-back
  // ****************************************************************
  wire [15:0] status_word = {1'b0, received,
                             sound_reg.present,
                             2'b00, err_count_reg};
  wire [15:0] law_word    = sound_reg.law;
  // Strobe bits read as zero since they are never held
  wire [15:0] ctrl_view   = ctrl_reg;

  always_comb begin
    rd_data_next = 16'h0000;  // Unmapped addresses read zero
    if (hit_ctrl) begin
      rd_data_next = ctrl_view;
    end else if (hit_test) begin
      rd_data_next = test_reg;
    end else if (hit_status) begin
      rd_data_next = status_word;
    end else if (hit_law) begin
      rd_data_next = law_word;
    end else if (hit_synd) begin
      rd_data_next = syndrome;
    end else if (hit_data) begin
      rd_data_next = data_word;
    end
  end

  // Answer one cycle after the read request
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_reg  <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= req.rd;
      if (req.rd) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  assign rd_data             = rd_data_reg;
  assign rd_valid            = rd_valid_reg;
  assign sbus_chan_enable    = ctrl_reg[`SPSR_CTRL_SBE_LSB +: 4];
  assign sbus_out_disable    = ctrl_reg[`SPSR_CTRL_DSB];
  assign descrambler_enable  = test_reg[`SPSR_TEST_DESCR];
  assign concealment_disable = test_reg[`SPSR_TEST_NOCONC];
  assign test_bits           = test_reg;

endmodule

// ===== hw/spsr_params.svh
`ifndef SPSR_PARAMS_SVH
`define SPSR_PARAMS_SVH

// ****************************************************************
// Register addresses on the serial control bus
// ****************************************************************
`define SPSR_ADDR_CTRL      8'hCC
`define SPSR_ADDR_TEST      8'hCD
`define SPSR_ADDR_STATUS    8'hCE
`define SPSR_ADDR_LAW       8'hD0
`define SPSR_ADDR_SYND      8'hD1
`define SPSR_ADDR_DATA      8'hD2

// ****************************************************************
// Field positions
// ****************************************************************
`define SPSR_CTRL_SBE_LSB   0
`define SPSR_CTRL_DGT_LSB   4
`define SPSR_CTRL_REWIND    8
`define SPSR_CTRL_ARM       9
`define SPSR_CTRL_DSB       10
`define SPSR_ST_ERR_LSB     0
`define SPSR_ST_SOUND_LSB   10
`define SPSR_ST_RECV        14
`define SPSR_TEST_DESCR     6
`define SPSR_TEST_NOCONC    8

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define SPSR_CTRL_RESET     16'h0000
`define SPSR_TEST_RESET     16'h0000
`define SPSR_HDRS_PER_FRAME 7'h52
`define SPSR_CTRL_WMASK     16'h04FF

`endif

// ===== hw/spsr_pkg.sv
package spsr_pkg;

  // Coding law flags of one sound channel
  typedef struct packed {
    logic stereo;      // 0 mono, 1 stereo
    logic quality;     // 0 medium, 1 high
    logic protection;  // 0 first level, 1 second level
    logic law;         // 0 companded, 1 linear
  } spsr_law_t;

  // Per-frame status from the sound processor
  typedef struct packed {
    logic [3:0]      present;
    spsr_law_t [3:0] law;
  } spsr_sound_t;

  // One byte of the packet stream
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } spsr_byte_t;

  // Control-bus request, already decoded from the serial frame
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } spsr_req_t;

  typedef enum logic [1:0] {SPSR_IDLE, SPSR_ARMED, SPSR_STORE, SPSR_FULL}
    spsr_state_t;

endpackage

// ===== hw/spsr_pkt0_buf.sv
`timescale 1ns/100ps
`include "spsr_params.svh"

module spsr_pkt0_buf #(
  parameter int DEPTH = 64
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              arm,
  input  wire logic              rewind,
  input  wire logic              advance,
  input  wire logic [3:0]        group_type_select,
  input  wire spsr_pkg::spsr_byte_t pkt_in,
  input  wire logic [15:0]       syndrome_in,
  output logic                   received,
  output logic [15:0]            data_word,
  output logic [15:0]            syndrome
);

  localparam int AW = $clog2(DEPTH);

  logic [7:0]              mem [DEPTH];
  spsr_pkg::spsr_state_t   state_reg;
  spsr_pkg::spsr_state_t   state_next;
  logic [AW-1:0]           wptr_reg;
  logic [AW-1:0]           rptr_reg;
  logic                    recv_reg;
  logic [15:0]             synd_reg;

  // ****************************************************************
  // Capture decode
  // ****************************************************************
  // First byte carries the group type; only a matching packet is kept
  wire type_match = pkt_in.data[3:0] == group_type_select;
  wire start_ok   = pkt_in.valid && pkt_in.first && type_match;
  wire store_en   = (state_reg == spsr_pkg::SPSR_ARMED && start_ok) ||
                    (state_reg == spsr_pkg::SPSR_STORE && pkt_in.valid);
  wire done       = store_en && pkt_in.last;
  wire room       = wptr_reg != AW'(DEPTH - 1);

  // Next state of the capture sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spsr_pkg::SPSR_IDLE:  state_next = state_reg;
      spsr_pkg::SPSR_ARMED: if (start_ok) begin
        state_next = pkt_in.last ? spsr_pkg::SPSR_FULL
                                 : spsr_pkg::SPSR_STORE;
      end
      spsr_pkg::SPSR_STORE: if (done) begin
        state_next = spsr_pkg::SPSR_FULL;
      end
      spsr_pkg::SPSR_FULL:  state_next = state_reg;
      default:              state_next = spsr_pkg::SPSR_IDLE;
    endcase
    if (arm) begin
      state_next = spsr_pkg::SPSR_ARMED;
    end
  end

  // ****************************************************************
  // State and pointers
  // ****************************************************************
  // A new arm restarts capture; a packet ending the same cycle still counts
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= spsr_pkg::SPSR_IDLE;
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      recv_reg  <= 1'b0;
      synd_reg  <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (arm) begin
        wptr_reg <= '0;
      end else if (store_en && room) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (done) begin
        recv_reg <= 1'b1;
        synd_reg <= syndrome_in;
      end else if (arm) begin
        recv_reg <= 1'b0;
      end
      if (rewind) begin
        rptr_reg <= '0;
      end else if (advance) begin
        rptr_reg <= rptr_reg + AW'(2);
      end
    end
  end

  // Byte storage; excess bytes of an overlong packet overwrite the last
  always_ff @(posedge core_clk) begin
    if (store_en && !arm) begin
      mem[wptr_reg] <= pkt_in.data;
    end
  end

  // Low byte at the read pointer, high byte after it
  assign data_word = {mem[rptr_reg + AW'(1)], mem[rptr_reg]};
  assign received  = recv_reg;
  assign syndrome  = synd_reg;

endmodule

// ===== verification/spsr_regs_sva.sv
`timescale 1ns/100ps
// ****************************************************************
// Read-back, test word write and test pin checks at the register bank ports
// ****************************************************************
module spsr_regs_sva (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire spsr_pkg::spsr_req_t   req,
  input wire logic [15:0]           rd_data,
  input wire logic                  rd_valid,
  input wire spsr_pkg::spsr_sound_t sound_in,
  input wire logic [15:0]           test_bits,
  input wire logic                  descrambler_enable,
  input wire logic                  concealment_disable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Sound checks need the cycle before the read out of reset
  AST_RD_ANSWER: assert property (req.rd |=> rd_valid)
    else $error("read not answered");
  AST_NO_SPURIOUS: assert property (!req.rd |=> !rd_valid)
    else $error("answer without read");
  AST_RD_HOLD: assert property (!req.rd |=> $stable(rd_data))
    else $error("read data moved without read");
  AST_STATUS_SOUND: assert property (
    req.rd && req.addr == 8'hCE && $past(rst_n)
    |=> rd_data[13:10] == $past(sound_in.present, 2))
    else $error("sound presence bits wrong");
  AST_STATUS_RSVD: assert property (
    req.rd && req.addr == 8'hCE
    |=> rd_data[15] == 1'b0 && rd_data[9:8] == 2'b00)
    else $error("status spare bits set");
  AST_LAW_WORD: assert property (
    req.rd && req.addr == 8'hD0 && $past(rst_n)
    |=> rd_data == $past(sound_in.law, 2))
    else $error("coding law word wrong");
  AST_UNMAPPED: assert property (
    req.rd && req.addr == 8'h00 |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  AST_TEST_WR: assert property (req.wr && req.addr == 8'hCD
    |=> test_bits == $past(req.wdata))
    else $error("test word not written");
  AST_TEST_PINS: assert property (descrambler_enable == test_bits[6]
    && concealment_disable == test_bits[8])
    else $error("test pins differ from test word");
endmodule

bind spsr_regs spsr_regs_sva spsr_regs_sva_i (
  .core_clk            (core_clk),
  .rst_n               (rst_n),
  .req                 (req),
  .rd_data             (rd_data),
  .rd_valid            (rd_valid),
  .sound_in            (sound_in),
  .test_bits           (test_bits),
  .descrambler_enable  (descrambler_enable),
  .concealment_disable (concealment_disable)
);

// ===== verification/spsr_pkt_src.sv
`timescale 1ns/100ps
// ****************************************************************
// Packet byte source standing in for the packet demultiplexer
// ****************************************************************
module spsr_pkt_src (
  input wire logic             core_clk,
  output spsr_pkg::spsr_byte_t pkt,
  output logic [15:0]          syndrome
);
  initial begin
    pkt = '0;
    syndrome = 16'hFFFF;
  end

  // Idle data is inverted so a stale byte never looks valid by chance
  task automatic send(input logic [31:0] bytes, input int n,
                      input logic [15:0] syn);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      pkt <= {1'b1, i == 0, i == n - 1, bytes[8*i +: 8]};
      syndrome <= (i == n - 1) ? syn : ~syn;
    end
    @(posedge core_clk);
    pkt <= {3'h0, ~bytes[8*(n-1) +: 8]};
    syndrome <= ~syn;
  endtask
endmodule

// ===== verification/sound_packet_status_regs_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module sound_packet_status_regs_tb_top;
  logic                  core_clk, rst_n, rd_valid, hdr_done, frame_start;
  logic                  sbus_out_disable, descrambler_enable;
  logic                  concealment_disable;
  logic [2:0]            hdr_err_bits;
  logic [3:0]            sbus_chan_enable;
  logic [15:0]           rd_data, syn, test_bits;
  spsr_pkg::spsr_req_t   req;
  spsr_pkg::spsr_sound_t sound_in;
  spsr_pkg::spsr_byte_t  pkt;
  int                    n_mismatch, compares, cyc;
  logic [7:0]            ro [4] = '{8'hCE, 8'hD0, 8'hD1, 8'h00};
  logic [19:0]           snd [2] = '{{4'hA, 16'h5A3C}, {4'h5, 16'hA5C3}};

  spsr_regs #(.PKT_DEPTH(64)) spsr_regs_i (.core_clk(core_clk),
    .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .hdr_done(hdr_done), .hdr_err_bits(hdr_err_bits),
    .frame_start(frame_start), .sound_in(sound_in), .pkt_in(pkt),
    .syndrome_in(syn), .sbus_chan_enable(sbus_chan_enable),
    .sbus_out_disable(sbus_out_disable), .test_bits(test_bits),
    .descrambler_enable(descrambler_enable),
    .concealment_disable(concealment_disable));
  spsr_pkt_src spsr_pkt_src_i (.core_clk(core_clk), .pkt(pkt),
    .syndrome(syn));

  // ****************************************************************
  // Clock, hang guard and bus tasks
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // The whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge core_clk);
    req <= '0;
  endtask

  // Answer is taken mid-cycle, well clear of the edge that updates it
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [15:0] e);
    @(posedge core_clk);
    req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk);
    req <= '0;
    @(negedge core_clk);
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK(nm, e, rd_data)
  endtask

  function automatic logic [15:0] st(input logic r, input logic [3:0] p,
                                     input logic [7:0] c);
    return {1'b0, r, p, 2'b00, c};
  endfunction

  // Pause before the last header so an early publish shows up
  task automatic hdr_frame(input bit sat, input logic [7:0] prev,
                           input logic [7:0] cnt);
    @(posedge core_clk);
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    for (int i = 0; i < 82; i++) begin
      if (i == 81) begin
        @(posedge core_clk);
        hdr_done <= 1'b0;
        rd_chk("count early", 8'hCE, st(1'b0, 4'h5, prev));
      end
      @(posedge core_clk);
      hdr_done <= 1'b1;
      hdr_err_bits <= sat ? 3'h7 : 3'(i % 4);
    end
    @(posedge core_clk);
    hdr_done <= 1'b0;
    rd_chk("count", 8'hCE, st(1'b0, 4'h5, cnt));
    $display("test header count done");
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    req = '0;
    hdr_done = 1'b0;
    hdr_err_bits = 3'h0;
    frame_start = 1'b0;
    sound_in = '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk("ctrl", 8'hCC, 16'h0000);
    rd_chk("test", 8'hCD, 16'h0000);
    rd_chk("status", 8'hCE, 16'h0000);
    rd_chk("synd", 8'hD1, 16'h0000);
    $display("test reset done");
    bus_wr(8'hCC, 16'hFCFF);
    rd_chk("ctrl", 8'hCC, 16'h04FF);
    `CHK("sbus_en", 4'hF, sbus_chan_enable)
    `CHK("sbus_dis", 1'b1, sbus_out_disable)
    bus_wr(8'hCD, 16'hA5C3);
    rd_chk("test", 8'hCD, 16'hA5C3);
    `CHK("test_bits", 16'hA5C3, test_bits)
    foreach (ro[k]) begin
      bus_wr(ro[k], 16'hFFFF);
      rd_chk("read only", ro[k], 16'h0000);
    end
    $display("test access done");
    foreach (snd[k]) begin
      @(posedge core_clk);
      sound_in <= snd[k];
      rd_chk("presence", 8'hCE, st(1'b0, snd[k][19:16], 8'h00));
      rd_chk("law", 8'hD0, snd[k][15:0]);
    end
    $display("test sound done");
    hdr_frame(1'b0, 8'h00, 8'h79);
    hdr_frame(1'b1, 8'h79, 8'hFF);
    bus_wr(8'hCC, 16'h0210);
    rd_chk("not yet", 8'hCE, st(1'b0, 4'h5, 8'hFF));
    spsr_pkt_src_i.send(32'hEEDD_CC02, 4, 16'h5555);
    rd_chk("other type", 8'hCE, st(1'b0, 4'h5, 8'hFF));
    spsr_pkt_src_i.send(32'hCCBB_AA01, 4, 16'h1234);
    rd_chk("received", 8'hCE, st(1'b1, 4'h5, 8'hFF));
    rd_chk("syndrome", 8'hD1, 16'h1234);
    // A write to the data word must not disturb the stored packet
    bus_wr(8'hD2, 16'hFFFF);
    bus_wr(8'hCC, 16'h0110);
    rd_chk("data", 8'hD2, 16'hAA01);
    rd_chk("data", 8'hD2, 16'hCCBB);
    bus_wr(8'hCC, 16'h0110);
    rd_chk("rewound", 8'hD2, 16'hAA01);
    bus_wr(8'hCC, 16'h0210);
    rd_chk("rearmed", 8'hCE, st(1'b0, 4'h5, 8'hFF));
    $display("test packet done");
    tally_and_finish();
  end
endmodule
